/* logic/gp_control.sv */
// Mode decode, supply supervision and control input handling for a glow
// plug driver. Assumes straps are stable at reset release, comparator and
// pin levels are synchronous to mclk, and power regulation arithmetic,
// current monitoring and diagnostic framing live in neighbouring blocks.
//
// Overview of operation
// - Six modes decoded from mode strap, battery strap and IO strap.
// - Modes 1-2 drive the relay output; modes 3-6 drive gate drivers.
// - Serial reporting except mode 1, which uses go/no-go reporting.
// - Modes 3-4 shunt sense; modes 5-6 on-resistance with compensation.
// - Modes 3 and 5 take gate timing straight from the command input.
// - Modes 4 and 6 treat command timing as a power request.
// - Supply low for filter time: plugs off, under voltage flagged.
// - Supply high for filter time: plugs off, over voltage flagged.
// - Load dump forces plugs on until supply not high for filter time.
// - Open-load detection suppressed while supply under enable level.
// - Supply switch-off releases by itself once its condition clears.
// - Modes 2-6 enable the battery pin as auxiliary supply.
// - Modes 2-6 flag battery under voltage after battery filter time.
// - Pump low for filter time: plugs off until command turns them on.
// - Undriven command input reads as off; plugs stay off.
// - Falling edge means on, rising edge off; short glitches ignored.
// - Modes 3-6 restart on-time and period measurement at each falling edge.
// - Modes 3-6: no falling edge within timeout ends the group; plugs off.
// - First low pulse above override level holds plugs on while low.
// - Mode 2 relay filters pulses shorter than the suppress time.
// - Mode 1 relay follows the static command level directly.
// - Suppress time is counted digitally within 2.5 ms to 5 ms.
`timescale 1ns/100ps
module gp_control
   import gp_pkg::*;
#(
   parameter int SUPPLY_FILTER_CYC  = GP_SUPPLY_FILTER_CYC,
   parameter int LOAD_DUMP_CYC      = GP_LOAD_DUMP_CYC,
   parameter int BATTERY_FILTER_CYC = GP_BATTERY_FILTER_CYC,
   parameter int PUMP_FILTER_CYC    = GP_PUMP_FILTER_CYC,
   parameter int SUPPRESS_CYC       = GP_SUPPRESS_CYC,
   parameter int TIMEOUT_CYC        = GP_TIMEOUT_CYC
) (
   input  wire logic                mclk,
   input  wire logic                rst_b,
   input  wire gp_straps_t          straps,
   input  wire gp_sense_t           sense,
   input  wire logic                command_input_pin,
   input  wire logic                command_above_override,
   output gp_cfg_t                  cfg,
   output gp_fault_t                fault,
   output logic                     openload_detect_enable,
   output logic                     gate_driver_enable,
   output logic                     gate_on,
   output logic                     relay_on,
   output logic [GP_CNT_W-1:0]      low_pulse_width,
   output logic                     low_pulse_valid,
   output logic [GP_CNT_W-1:0]      command_period,
   output logic                     command_period_valid
);

   localparam logic [GP_CNT_W-1:0] CI_LIM  = GP_CNT_W'(GP_CI_FILTER_CYC - 1);
   localparam logic [GP_CNT_W-1:0] SUP_LIM = GP_CNT_W'(SUPPRESS_CYC);
   localparam logic [GP_CNT_W-1:0] TO_LIM  = GP_CNT_W'(TIMEOUT_CYC);
   localparam logic [GP_CNT_W-1:0] CNT_MAX = '1;
   localparam int FCOUNT [GP_NFILT] = '{
      SUPPLY_FILTER_CYC, SUPPLY_FILTER_CYC, LOAD_DUMP_CYC,
      SUPPLY_FILTER_CYC, BATTERY_FILTER_CYC, PUMP_FILTER_CYC
   };

   typedef struct packed {
      gp_cfg_t             cfg;
      logic                ci_level;
      logic [GP_CNT_W-1:0] ci_cnt;
      logic                group_active;
      logic                override_hold;
      logic [GP_CNT_W-1:0] period_cnt;
      logic [GP_CNT_W-1:0] on_cnt;
      logic                timing_low;
      logic [GP_CNT_W-1:0] low_pulse_width;
      logic                low_pulse_valid;
      logic [GP_CNT_W-1:0] command_period;
      logic                command_period_valid;
      logic                first_fall_seen;
      logic                relay_follow;
      logic [GP_CNT_W-1:0] sup_cnt;
      logic                load_dump_hold;
      logic                pump_lock;
      logic                openload_en;
      logic                gate_en;
      logic                gate_on;
      logic                relay_on;
   } gp_ctrl_state_t;

   gp_ctrl_state_t       state;
   gp_ctrl_state_t       next_state;
   logic [GP_NFILT-1:0]  filt_raw;
   logic [GP_NFILT-1:0]  filt_hit;

   // ======================================================================
   // Fault filters
   always_comb begin
      filt_raw              = '0;
      filt_raw[GP_F_UV]     = sense.supply_below_low;
      filt_raw[GP_F_OV]     = sense.supply_above_high;
      filt_raw[GP_F_LD]     = sense.supply_above_load_dump;
      filt_raw[GP_F_LD_REL] = !sense.supply_above_high;
      filt_raw[GP_F_BAT]    = sense.battery_below_low && state.cfg.valid &&
                              (state.cfg.mode != GP_MODE_1);
      filt_raw[GP_F_PUMP]   = sense.pump_below_low;
   end

   genvar gi;
   generate
      for (gi = 0; gi < GP_NFILT; gi++) begin : g_filt
         gp_filter #(
            .COUNT (FCOUNT[gi])
         ) u_filt (
            .mclk  (mclk),
            .rst_b (rst_b),
            .raw   (filt_raw[gi]),
            .hit   (filt_hit[gi])
         );
      end
   endgenerate

   // ======================================================================
   // Next state
   always_comb begin
      logic ci_on;
      logic ci_fall;
      logic ci_rise;
      logic transistor;
      logic request;
      logic plugs_on;
      logic supply_off;
      gp_mode_t m;
      ci_on      = 1'b0;
      ci_fall    = 1'b0;
      ci_rise    = 1'b0;
      transistor = 1'b0;
      request    = 1'b0;
      plugs_on   = 1'b0;
      supply_off = 1'b0;
      m          = GP_MODE_NONE;
      next_state = state;
      next_state.low_pulse_valid      = 1'b0;
      next_state.command_period_valid = 1'b0;

      // Straps are caught once, in the first cycle after reset release
      if (!state.cfg.valid) begin
         if (straps.ms_grounded) begin
            m = straps.bat_grounded ? GP_MODE_1 : GP_MODE_2;
         end else if (straps.ms_to_cur) begin
            m = straps.io_to_cur ? GP_MODE_3 : GP_MODE_4;
         end else begin
            m = straps.io_to_cur ? GP_MODE_5 : GP_MODE_6;
         end
         next_state.cfg.mode  = m;
         next_state.cfg.valid = 1'b1;
         next_state.cfg.relay_mode =
            (m == GP_MODE_1) || (m == GP_MODE_2);
         next_state.cfg.serial_protocol  = (m != GP_MODE_1);
         next_state.cfg.shunt_sense      =
            (m == GP_MODE_3) || (m == GP_MODE_4);
         next_state.cfg.temp_comp        =
            (m == GP_MODE_5) || (m == GP_MODE_6);
         next_state.cfg.direct_timing    =
            (m == GP_MODE_3) || (m == GP_MODE_5);
         next_state.cfg.power_regulation =
            (m == GP_MODE_4) || (m == GP_MODE_6);
         next_state.cfg.aux_supply       = (m != GP_MODE_1);
      end

      // Command input deglitch; pin high is the off level
      if (command_input_pin == state.ci_level) begin
         next_state.ci_cnt = '0;
      end else if (state.ci_cnt == CI_LIM) begin
         next_state.ci_cnt   = '0;
         next_state.ci_level = command_input_pin;
      end else begin
         next_state.ci_cnt = state.ci_cnt + 1'b1;
      end
      ci_on   = !state.ci_level;
      ci_fall = state.ci_level && !next_state.ci_level;
      ci_rise = !state.ci_level && next_state.ci_level;
      transistor = state.cfg.valid && !state.cfg.relay_mode;

      // On-time and period measurement, pulse group supervision
      if (state.period_cnt != CNT_MAX) begin
         next_state.period_cnt = state.period_cnt + 1'b1;
      end
      if (state.timing_low && (state.on_cnt != CNT_MAX)) begin
         next_state.on_cnt = state.on_cnt + 1'b1;
      end
      if (transistor && ci_fall) begin
         if (state.first_fall_seen) begin
            next_state.command_period       = state.period_cnt + 1'b1;
            next_state.command_period_valid = 1'b1;
         end
         next_state.first_fall_seen = 1'b1;
         next_state.period_cnt      = '0;
         next_state.on_cnt          = '0;
         next_state.timing_low      = 1'b1;
         if (!state.group_active) begin
            next_state.override_hold = command_above_override;
         end
         next_state.group_active = 1'b1;
      end else if (transistor && ci_rise) begin
         if (state.timing_low) begin
            next_state.low_pulse_width = state.on_cnt + 1'b1;
            next_state.low_pulse_valid = 1'b1;
         end
         next_state.timing_low    = 1'b0;
         next_state.override_hold = 1'b0;
      end
      if (!ci_fall && state.group_active && (state.period_cnt >= TO_LIM) &&
          !(state.override_hold && ci_on)) begin
         next_state.group_active    = 1'b0;
         next_state.first_fall_seen = 1'b0;
         next_state.override_hold   = 1'b0;
      end

      // Relay request: mode 1 follows level, mode 2 suppresses short pulses
      if (state.cfg.mode == GP_MODE_1) begin
         next_state.relay_follow = ci_on;
         next_state.sup_cnt      = '0;
      end else if (state.cfg.mode == GP_MODE_2) begin
         if (ci_on == state.relay_follow) begin
            next_state.sup_cnt = '0;
         end else if (state.sup_cnt >= SUP_LIM - 1'b1) begin
            next_state.sup_cnt      = '0;
            next_state.relay_follow = ci_on;
         end else begin
            next_state.sup_cnt = state.sup_cnt + 1'b1;
         end
      end else begin
         next_state.relay_follow = 1'b0;
         next_state.sup_cnt      = '0;
      end

      // Load dump latch and pump lockout; setting wins over release
      if (filt_hit[GP_F_LD]) begin
         next_state.load_dump_hold = 1'b1;
      end else if (filt_hit[GP_F_LD_REL]) begin
         next_state.load_dump_hold = 1'b0;
      end
      if (filt_hit[GP_F_PUMP]) begin
         next_state.pump_lock = 1'b1;
      end else if (ci_fall) begin
         next_state.pump_lock = 1'b0;
      end

      // Output gating; supply faults release as their filters drop
      supply_off = filt_hit[GP_F_UV] || filt_hit[GP_F_OV];
      if (transistor) begin
         request = state.group_active && ci_on;
      end else begin
         request = state.relay_follow;
      end
      plugs_on = state.cfg.valid && (state.load_dump_hold ||
                 (request && !supply_off && !state.pump_lock));
      next_state.gate_on  = transistor && plugs_on;
      next_state.relay_on = state.cfg.valid && state.cfg.relay_mode &&
                            plugs_on;
      next_state.gate_en  = next_state.cfg.valid &&
                            !next_state.cfg.relay_mode;
      next_state.openload_en = !sense.supply_below_openload;
   end

   // ======================================================================
   // State register
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state          <= '0;
         state.ci_level <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   // ======================================================================
   // Outputs
   assign cfg                         = state.cfg;
   assign fault.under_voltage         = filt_hit[GP_F_UV];
   assign fault.over_voltage          = filt_hit[GP_F_OV];
   assign fault.load_dump             = state.load_dump_hold;
   assign fault.battery_under_voltage = filt_hit[GP_F_BAT];
   assign fault.pump_under_voltage    = filt_hit[GP_F_PUMP];
   assign openload_detect_enable      = state.openload_en;
   assign gate_driver_enable          = state.gate_en;
   assign gate_on                     = state.gate_on;
   assign relay_on                    = state.relay_on;
   assign low_pulse_width             = state.low_pulse_width;
   assign low_pulse_valid             = state.low_pulse_valid;
   assign command_period              = state.command_period;
   assign command_period_valid        = state.command_period_valid;

endmodule

/* logic/gp_pkg.sv */
// Shared constants and carrier types for the glow plug mode and control block.
// Assumes a 50 MHz mclk; every sensed analogue condition arrives as a
// comparator level that is already synchronous to mclk.
package gp_pkg;

   // =====================================================================
   // Clock and counter sizing
   localparam int GP_CLK_PERIOD_NS = 20;
   localparam int GP_CNT_W         = 24;

   // =====================================================================
   // Times in their own unit, cycle counts derived from them
   localparam int GP_CI_FILTER_US  = 20;
   localparam int GP_CI_FILTER_CYC =
      (GP_CI_FILTER_US * 1000 + GP_CLK_PERIOD_NS - 1) / GP_CLK_PERIOD_NS;
   localparam int GP_SUPPLY_FILTER_US  = 1000;
   localparam int GP_SUPPLY_FILTER_CYC =
      (GP_SUPPLY_FILTER_US * 1000 + GP_CLK_PERIOD_NS - 1) / GP_CLK_PERIOD_NS;
   localparam int GP_LOAD_DUMP_US  = 1000;
   localparam int GP_LOAD_DUMP_CYC =
      (GP_LOAD_DUMP_US * 1000 + GP_CLK_PERIOD_NS - 1) / GP_CLK_PERIOD_NS;
   localparam int GP_BATTERY_FILTER_US  = 1000;
   localparam int GP_BATTERY_FILTER_CYC =
      (GP_BATTERY_FILTER_US * 1000 + GP_CLK_PERIOD_NS - 1) / GP_CLK_PERIOD_NS;
   localparam int GP_PUMP_FILTER_US  = 1000;
   localparam int GP_PUMP_FILTER_CYC =
      (GP_PUMP_FILTER_US * 1000 + GP_CLK_PERIOD_NS - 1) / GP_CLK_PERIOD_NS;
   // Relay pulse suppress window is 2.5 ms to 5 ms; the least figure is used
   localparam int GP_SUPPRESS_US  = 2500;
   localparam int GP_SUPPRESS_CYC =
      (GP_SUPPRESS_US * 1000 + GP_CLK_PERIOD_NS - 1) / GP_CLK_PERIOD_NS;
   // Pulse group timeout is a longest time, so it rounds down
   localparam int GP_TIMEOUT_US  = 100000;
   localparam int GP_TIMEOUT_CYC =
      (GP_TIMEOUT_US * 1000) / GP_CLK_PERIOD_NS;

   // =====================================================================
   // Fault filter slots
   localparam int GP_NFILT       = 6;
   localparam int GP_F_UV        = 0;
   localparam int GP_F_OV        = 1;
   localparam int GP_F_LD        = 2;
   localparam int GP_F_LD_REL    = 3;
   localparam int GP_F_BAT       = 4;
   localparam int GP_F_PUMP      = 5;

   // =====================================================================
   // Types
   typedef enum logic [2:0] {
      GP_MODE_NONE = 3'b000,
      GP_MODE_1    = 3'b001,
      GP_MODE_2    = 3'b010,
      GP_MODE_3    = 3'b011,
      GP_MODE_4    = 3'b100,
      GP_MODE_5    = 3'b101,
      GP_MODE_6    = 3'b110
   } gp_mode_t;

   typedef struct packed {
      logic ms_grounded;
      logic ms_to_cur;
      logic bat_grounded;
      logic io_to_cur;
   } gp_straps_t;

   typedef struct packed {
      logic supply_below_low;
      logic supply_above_high;
      logic supply_above_load_dump;
      logic supply_below_openload;
      logic battery_below_low;
      logic pump_below_low;
   } gp_sense_t;

   typedef struct packed {
      gp_mode_t mode;
      logic     valid;
      logic     relay_mode;
      logic     serial_protocol;
      logic     shunt_sense;
      logic     temp_comp;
      logic     direct_timing;
      logic     power_regulation;
      logic     aux_supply;
   } gp_cfg_t;

   typedef struct packed {
      logic under_voltage;
      logic over_voltage;
      logic load_dump;
      logic battery_under_voltage;
      logic pump_under_voltage;
   } gp_fault_t;

endpackage

/* logic/gp_filter.sv */
// Fault filter: a raw comparator level must hold for COUNT cycles.
// Assumes raw is synchronous to mclk.
`timescale 1ns/100ps
module gp_filter
   import gp_pkg::*;
#(
   parameter int COUNT = 1
) (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic raw,
   output logic      hit
);

   localparam logic [GP_CNT_W-1:0] LIMIT = GP_CNT_W'(COUNT);

   typedef struct packed {
      logic [GP_CNT_W-1:0] cnt;
      logic                hit;
   } gp_filter_state_t;

   gp_filter_state_t state;
   gp_filter_state_t next_state;

   // ======================================================================
   // Counter restarts whenever the raw condition clears
   always_comb begin
      next_state = state;
      if (!raw) begin
         next_state.cnt = '0;
      end else if (state.cnt != LIMIT) begin
         next_state.cnt = state.cnt + 1'b1;
      end
      next_state.hit = raw && (next_state.cnt == LIMIT);
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign hit = state.hit;

endmodule

/* bench/gp_chk.sv */
// Port-level assertions for the glow plug mode and control block.
// Assumes it is bound to gp_control and sees only that module's ports.
`timescale 1ns/100ps
module gp_chk
   import gp_pkg::*;
#(
   parameter int SUPPLY_FILTER_CYC = GP_SUPPLY_FILTER_CYC,
   parameter int TIMEOUT_CYC       = GP_TIMEOUT_CYC
) (
   input wire logic                mclk,
   input wire logic                rst_b,
   input wire gp_straps_t          straps,
   input wire gp_sense_t           sense,
   input wire logic                command_input_pin,
   input wire logic                command_above_override,
   input wire gp_cfg_t             cfg,
   input wire gp_fault_t           fault,
   input wire logic                openload_detect_enable,
   input wire logic                gate_driver_enable,
   input wire logic                gate_on,
   input wire logic                relay_on,
   input wire logic [GP_CNT_W-1:0] low_pulse_width,
   input wire logic                low_pulse_valid,
   input wire logic [GP_CNT_W-1:0] command_period,
   input wire logic                command_period_valid
);
   // ==================================================================
   // Run-length helpers
   logic [23:0] lo_run, hi_run, prev_lo, uv_run;
   logic [7:0]  quiet;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         lo_run  <= 24'h0;
         hi_run  <= 24'h0;
         prev_lo <= 24'h0;
         uv_run  <= 24'h0;
         quiet   <= 8'h0;
      end else begin
         lo_run <= command_input_pin ? 24'h0 : lo_run + 24'h1;
         hi_run <= command_input_pin ? hi_run + 24'h1 : 24'h0;
         if (command_input_pin && lo_run != 24'h0)
            prev_lo <= lo_run;
         uv_run <= sense.supply_below_low ? uv_run + 24'h1 : 24'h0;
         // Counts cycles since any high-supply or load dump activity
         if (fault.load_dump || sense.supply_above_high ||
             sense.supply_above_load_dump)
            quiet <= 8'h0;
         else if (quiet != 8'hff)
            quiet <= quiet + 8'h1;
      end
   end

   // ==================================================================
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   decode_ok_a: assert property (
      cfg.valid |-> cfg.relay_mode == (cfg.mode inside {GP_MODE_1, GP_MODE_2})
      && cfg.serial_protocol == (cfg.mode != GP_MODE_1)
      && cfg.aux_supply == (cfg.mode != GP_MODE_1)
      && gate_driver_enable == !cfg.relay_mode)
      else $error("mode decode outputs inconsistent");
   cfg_hold_a: assert property (cfg.valid |=> $stable(cfg))
      else $error("configuration changed while valid");
   drive_split_a: assert property (
      cfg.valid && quiet >= 8'h40 |-> !(cfg.relay_mode ? gate_on : relay_on))
      else $error("wrong output kind driven for mode");
   filt_clear_a: assert property (
      !sense.supply_below_low [*2] |-> !fault.under_voltage)
      else $error("under voltage stays after condition cleared");
   uv_filter_a: assert property (
      $rose(fault.under_voltage) |-> uv_run >= SUPPLY_FILTER_CYC - 1)
      else $error("under voltage flagged before filter time");
   plug_off_a: assert property (
      (fault.under_voltage || (fault.pump_under_voltage &&
       $past(fault.pump_under_voltage))) && quiet >= 8'h40
      |=> !gate_on && !relay_on)
      else $error("plugs on during supply or pump fault");
   ld_force_a: assert property (
      cfg.valid && fault.load_dump && !cfg.relay_mode |=> gate_on)
      else $error("plugs not forced on in load dump");
   idle_off_a: assert property (
      hi_run >= 24'h3f2 && quiet >= 8'h40
      |-> !gate_on && (cfg.mode == GP_MODE_2 || !relay_on))
      else $error("plugs on with command at off level");
   glitch_a: assert property (
      $rose(gate_on) && !fault.load_dump |-> lo_run >= 24'h3e8)
      else $error("plugs switched on by a short low level");
   tmo_off_a: assert property (
      !cfg.relay_mode && !command_above_override && quiet >= 8'h40
      && lo_run >= TIMEOUT_CYC + 1010 |-> !gate_on)
      else $error("plugs still on after pulse group timeout");
   width_a: assert property (
      low_pulse_valid |-> low_pulse_width == prev_lo)
      else $error("measured low pulse width wrong");
   openload_a: assert property (
      sense.supply_below_openload |=> !openload_detect_enable)
      else $error("open-load detection enabled at low supply");

   cover property ($rose(gate_on));
   cover property (low_pulse_valid);
   cover property (command_period_valid);
   cover property (fault.load_dump);
endmodule

bind gp_control gp_chk #(
   .SUPPLY_FILTER_CYC(SUPPLY_FILTER_CYC),
   .TIMEOUT_CYC      (TIMEOUT_CYC)
) u_chk (
   .mclk, .rst_b, .straps, .sense, .command_input_pin,
   .command_above_override, .cfg, .fault, .openload_detect_enable,
   .gate_driver_enable, .gate_on, .relay_on, .low_pulse_width,
   .low_pulse_valid, .command_period, .command_period_valid
);

/* bench/gp_ecu_model.sv */
// Engine controller model that drives the command input of the block.
// Assumes the caller enters drive just after a rising edge of mclk.
`timescale 1ns/100ps
module gp_ecu_model
   import gp_pkg::*;
(
   input wire logic mclk,
   output logic     command_input_pin,
   output logic     command_above_override
);
   // Pulled-up pin reads as the off level until driven
   initial begin
      command_input_pin      = 1'b1;
      command_above_override = 1'b0;
   end

   // Holds one level for a number of cycles; low is on, high is off
   task automatic drive(input logic level, input logic above, input int n);
      command_input_pin      = level;
      command_above_override = above;
      repeat (n) @(posedge mclk);
      #1;
   endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for gp_control over all six strap modes.
// Assumes the controller model in gp_ecu_model drives the command pin.
`timescale 1ns/100ps
module testbench
   import gp_pkg::*;
;
   typedef struct packed {
      gp_straps_t s;
      gp_mode_t   m;
   } gp_row_t;

   localparam gp_row_t ROWS [6] = '{'{4'ha, GP_MODE_1}, '{4'h8, GP_MODE_2},
      '{4'h5, GP_MODE_3}, '{4'h4, GP_MODE_4}, '{4'h1, GP_MODE_5},
      '{4'h0, GP_MODE_6}};

   logic                mclk, rst_b, cmd, ovr, ol_en, gd_en;
   logic                gate_on, relay_on, lpv, cpv, rel;
   logic [GP_CNT_W-1:0] lpw, cp;
   gp_straps_t          straps;
   gp_sense_t           sense;
   gp_cfg_t             cfg;
   gp_fault_t           fault;
   gp_mode_t            m;
   int                  num_errors = 0;
   int                  checked = 0;

   localparam int SIM_FILT = 20;
   gp_control #(
      .SUPPLY_FILTER_CYC(SIM_FILT), .LOAD_DUMP_CYC(SIM_FILT),
      .BATTERY_FILTER_CYC(SIM_FILT), .PUMP_FILTER_CYC(SIM_FILT),
      .SUPPRESS_CYC(1500), .TIMEOUT_CYC(6000)
   ) uut (
      .mclk(mclk), .rst_b(rst_b), .straps(straps), .sense(sense),
      .command_input_pin(cmd), .command_above_override(ovr), .cfg(cfg),
      .fault(fault), .openload_detect_enable(ol_en),
      .gate_driver_enable(gd_en), .gate_on(gate_on), .relay_on(relay_on),
      .low_pulse_width(lpw), .low_pulse_valid(lpv), .command_period(cp),
      .command_period_valid(cpv)
   );

   gp_ecu_model u_ecu (
      .mclk(mclk), .command_input_pin(cmd), .command_above_override(ovr)
   );

   // ==================================================================
   // Shared tasks
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic check(input string what, input logic [23:0] seen,
                        input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
         num_errors++;
      end
   endtask

   task automatic do_reset(input gp_straps_t s);
      rst_b  = 1'b0;
      straps = s;
      tick(3);
      rst_b = 1'b1;
      tick(3);
   endtask

   function automatic gp_cfg_t exp_cfg(input gp_mode_t md);
      gp_cfg_t e;
      e.mode             = md;
      e.valid            = 1'b1;
      e.relay_mode       = md inside {GP_MODE_1, GP_MODE_2};
      e.serial_protocol  = md != GP_MODE_1;
      e.shunt_sense      = md inside {GP_MODE_3, GP_MODE_4};
      e.temp_comp        = md inside {GP_MODE_5, GP_MODE_6};
      e.direct_timing    = md inside {GP_MODE_3, GP_MODE_5};
      e.power_regulation = md inside {GP_MODE_4, GP_MODE_6};
      e.aux_supply       = md != GP_MODE_1;
      return e;
   endfunction

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   initial begin
      repeat (100000) @(posedge mclk);
      num_errors++;
      stop_test;
   end

   // ==================================================================
   // Mode table, then hand-written cases
   initial begin
      rst_b  = 1'b0;
      sense  = '0;
      straps = '0;
      for (int i = 0; i < 6; i++) begin
         do_reset(ROWS[i].s);
         m   = ROWS[i].m;
         rel = m inside {GP_MODE_1, GP_MODE_2};
         check("cfg", 24'(cfg), 24'(exp_cfg(m)));
         check("gate_en", gd_en, !rel);
         check("idle", {gate_on, relay_on}, 2'h0);
         sense.battery_below_low = 1'b1;
         u_ecu.drive(1'b0, 1'b0, 3000);
         check("relay", relay_on, rel);
         check("gate", gate_on, !rel);
         check("bat_uv", fault.battery_under_voltage, m != GP_MODE_1);
         sense.battery_below_low = 1'b0;
         u_ecu.drive(1'b1, 1'b0, 2700);
         check("off", {gate_on, relay_on}, 2'h0);
         $display("row %0d done", i + 1);
      end
      do_reset(4'h5);
      u_ecu.drive(1'b0, 1'b0, 990);
      check("glitch", gate_on, 1'b0);
      u_ecu.drive(1'b1, 1'b0, 1100);
      u_ecu.drive(1'b0, 1'b0, 1200);
      u_ecu.drive(1'b1, 1'b0, 1300);
      u_ecu.drive(1'b0, 1'b0, 1200);
      u_ecu.drive(1'b1, 1'b0, 1100);
      check("width", lpw, 24'h4b0);
      check("period", cp, 24'h9c4);
      u_ecu.drive(1'b0, 1'b0, 7100);
      check("timeout", gate_on, 1'b0);
      u_ecu.drive(1'b1, 1'b0, 1100);
      u_ecu.drive(1'b0, 1'b1, 7100);
      check("override", gate_on, 1'b1);
      $display("command timing done");
      sense.pump_below_low = 1'b1;
      tick(30);
      check("pump", {fault.pump_under_voltage, gate_on}, 2'h2);
      sense.pump_below_low = 1'b0;
      tick(5);
      check("pump_lock", gate_on, 1'b0);
      u_ecu.drive(1'b1, 1'b0, 1100);
      u_ecu.drive(1'b0, 1'b1, 1100);
      check("pump_rel", gate_on, 1'b1);
      for (int k = 5; k >= 4; k--) begin
         sense[k] = 1'b1;
         tick(15);
         sense[k] = 1'b0;
         tick(1);
         sense[k] = 1'b1;
         tick(15);
         check("filter", fault[k-1], 1'b0);
         tick(10);
         check("supply", {fault[k-1], gate_on}, 2'h2);
         sense[k] = 1'b0;
         tick(5);
         check("resume", gate_on, 1'b1);
      end
      u_ecu.drive(1'b1, 1'b0, 1100);
      {sense.supply_above_high, sense.supply_above_load_dump} = 2'h3;
      tick(30);
      check("ld_on", {fault.load_dump, gate_on}, 2'h3);
      sense.supply_above_load_dump = 1'b0;
      tick(30);
      check("ld_hold", gate_on, 1'b1);
      sense.supply_above_high = 1'b0;
      tick(10);
      check("ld_hold", gate_on, 1'b1);
      tick(15);
      check("ld_rel", gate_on, 1'b0);
      sense.supply_below_openload = 1'b1;
      tick(2);
      check("openload", ol_en, 1'b0);
      sense.supply_below_openload = 1'b0;
      tick(3);
      check("openload", ol_en, 1'b1);
      $display("supply faults done");
      do_reset(4'h8);
      u_ecu.drive(1'b0, 1'b0, 3000);
      u_ecu.drive(1'b1, 1'b0, 1200);
      check("short_off", relay_on, 1'b1);
      u_ecu.drive(1'b0, 1'b0, 1200);
      u_ecu.drive(1'b1, 1'b0, 3000);
      u_ecu.drive(1'b0, 1'b0, 1200);
      check("short_on", relay_on, 1'b0);
      u_ecu.drive(1'b1, 1'b0, 1100);
      $display("relay suppress done");
      stop_test;
   end
endmodule
